/* File: pkg/jdp_regs.vh */
// constants for the test and debug port pin logic
`ifndef JDP_REGS_VH
`define JDP_REGS_VH

// ----------------------------------------------------------------------
// register widths
// ----------------------------------------------------------------------
`define JDP_IR_W          4
`define JDP_DR_W          32
`define JDP_USER_W        8
`define JDP_STATE_W       4

// ----------------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------------
`define JDP_OP_IDCODE     4'h1
`define JDP_OP_USER       4'h2
`define JDP_OP_BYPASS     4'hf

// ----------------------------------------------------------------------
// capture and reset values
// ----------------------------------------------------------------------
`define JDP_IR_CAPTURE    4'h1
`define JDP_IR_RESET      4'h1
`define JDP_USER_RESET    8'h00
`define JDP_SEL_RESET     1'h1

// ----------------------------------------------------------------------
// input synchroniser lane positions
// ----------------------------------------------------------------------
`define JDP_SYNC_W        5
`define JDP_LANE_TCK      0
`define JDP_LANE_TMS      1
`define JDP_LANE_TDI      2
`define JDP_LANE_TRST     3
`define JDP_LANE_SEL      4
// idle pin levels per lane: select high, test reset high, mode select high
`define JDP_SYNC_RESET    5'h1a

`endif

/* File: src/jdp_sync.v */
// two-flop input synchroniser with edge pulses, one lane per bit
`timescale 1ns/1ps

module jdp_sync #(
   parameter WIDTH = 5
) (
   input  wire             clk_in,
   input  wire             reset_in,
   input  wire [WIDTH-1:0] async_in,
   input  wire [WIDTH-1:0] reset_val_in,
   output wire [WIDTH-1:0] level_out,
   output wire [WIDTH-1:0] rise_out,
   output wire [WIDTH-1:0] fall_out
);

   // ----------------------------------------------------------------------
   // per-lane stages
   // ----------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
         reg meta;
         reg stable;
         reg prev;
         // first flop feeds only the second; edges come from later stages
         always @(posedge clk_in) begin
            if (reset_in) begin
               meta   <= reset_val_in[i];
               stable <= reset_val_in[i];
               prev   <= reset_val_in[i];
            end else begin
               meta   <= async_in[i];
               stable <= meta;
               prev   <= stable;
            end
         end
         // reset value keeps edges quiet until real levels arrive
         assign level_out[i] = stable;
         assign rise_out[i]  = stable & ~prev;
         assign fall_out[i]  = ~stable & prev;
      end
   endgenerate

endmodule // jdp_sync

/* File: src/jdp_port.v */
// test and debug port: pin sampling, test controller, shift registers
`timescale 1ns/1ps
`include "jdp_regs.vh"

module jdp_port #(
   parameter [31:0] ID_VALUE = 32'h00000001 // arbitrary identity value
) (
   input  wire        CLK_SYS_IN,
   input  wire        RESET_IN,
   input  wire        TCK_IN,
   input  wire        TMS_IN,
   input  wire        TDI_IN,
   input  wire        TRST_N_IN,
   input  wire        CTRL_SEL_IN,
   input  wire        FACTORY_TDO_IN,
   input  wire        SINGLE_WIRE_EN_IN,
   input  wire [7:0]  USER_DATA_IN,
   output reg         TDO_OUT,
   output reg         TDO_OE_OUT,
   output reg         RETURN_TEST_CLOCK_OUT,
   output reg         RETURN_TEST_CLOCK_OE_OUT,
   output reg         FACTORY_SEL_OUT,
   output reg  [3:0]  TAP_STATE_OUT,
   output reg  [3:0]  IR_OUT,
   output reg  [7:0]  USER_DATA_OUT,
   output reg         USER_UPDATE_OUT
);

   // ----------------------------------------------------------------------
   // controller states
   // ----------------------------------------------------------------------
   localparam [3:0] ST_RESET      = 4'h0;
   localparam [3:0] ST_IDLE       = 4'h1;
   localparam [3:0] ST_SEL_DR     = 4'h2;
   localparam [3:0] ST_CAPTURE_DR = 4'h3;
   localparam [3:0] ST_SHIFT_DR   = 4'h4;
   localparam [3:0] ST_EXIT1_DR   = 4'h5;
   localparam [3:0] ST_PAUSE_DR   = 4'h6;
   localparam [3:0] ST_EXIT2_DR   = 4'h7;
   localparam [3:0] ST_UPDATE_DR  = 4'h8;
   localparam [3:0] ST_SEL_IR     = 4'h9;
   localparam [3:0] ST_CAPTURE_IR = 4'ha;
   localparam [3:0] ST_SHIFT_IR   = 4'hb;
   localparam [3:0] ST_EXIT1_IR   = 4'hc;
   localparam [3:0] ST_PAUSE_IR   = 4'hd;
   localparam [3:0] ST_EXIT2_IR   = 4'he;
   localparam [3:0] ST_UPDATE_IR  = 4'hf;

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   wire [`JDP_SYNC_W-1:0] pin_level;
   wire [`JDP_SYNC_W-1:0] pin_rise;
   wire [`JDP_SYNC_W-1:0] pin_fall;
   wire [`JDP_SYNC_W-1:0] pin_async;

   assign pin_async = {CTRL_SEL_IN, TRST_N_IN, TDI_IN, TMS_IN, TCK_IN};

   jdp_sync #(
      .WIDTH        (`JDP_SYNC_W)
   ) u_sync (
      .clk_in       (CLK_SYS_IN),
      .reset_in     (RESET_IN),
      .async_in     (pin_async),
      .reset_val_in (`JDP_SYNC_RESET), // idle levels, so no false test reset rise
      .level_out    (pin_level),
      .rise_out     (pin_rise),
      .fall_out     (pin_fall)
   );

   wire tck_rise  = pin_rise[`JDP_LANE_TCK];
   wire tck_fall  = pin_fall[`JDP_LANE_TCK];
   wire tck_level = pin_level[`JDP_LANE_TCK];
   wire tms       = pin_level[`JDP_LANE_TMS];
   wire tdi       = pin_level[`JDP_LANE_TDI];
   wire trst_n    = pin_level[`JDP_LANE_TRST];
   wire trst_rise = pin_rise[`JDP_LANE_TRST];
   wire ctrl_sel  = pin_level[`JDP_LANE_SEL];

   // ----------------------------------------------------------------------
   // internal state
   // ----------------------------------------------------------------------
   reg  [3:0]  state;
   reg  [3:0]  next_state;
   reg  [3:0]  ir_sh;
   reg  [31:0] dr_sh;
   reg         factory_sel;

   // controller is held while the factory controller owns the port
   wire hold_reset = RESET_IN | ~trst_n | factory_sel;

   // ----------------------------------------------------------------------
   // controller select latch
   // ----------------------------------------------------------------------
   // select level is taken only when test reset releases
   always @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         factory_sel <= ~`JDP_SEL_RESET;
      end else if (trst_rise) begin
         factory_sel <= ~ctrl_sel;
      end
   end

   // ----------------------------------------------------------------------
   // next state of the controller
   // ----------------------------------------------------------------------
   // sixteen-state sequence steered by the sampled mode select
   always @* begin
      next_state = state;
      case (state)
         ST_RESET:      next_state = tms ? ST_RESET     : ST_IDLE;
         ST_IDLE:       next_state = tms ? ST_SEL_DR    : ST_IDLE;
         ST_SEL_DR:     next_state = tms ? ST_SEL_IR    : ST_CAPTURE_DR;
         ST_CAPTURE_DR: next_state = tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
         ST_SHIFT_DR:   next_state = tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
         ST_EXIT1_DR:   next_state = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
         ST_PAUSE_DR:   next_state = tms ? ST_EXIT2_DR  : ST_PAUSE_DR;
         ST_EXIT2_DR:   next_state = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
         ST_UPDATE_DR:  next_state = tms ? ST_SEL_DR    : ST_IDLE;
         ST_SEL_IR:     next_state = tms ? ST_RESET     : ST_CAPTURE_IR;
         ST_CAPTURE_IR: next_state = tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
         ST_SHIFT_IR:   next_state = tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
         ST_EXIT1_IR:   next_state = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
         ST_PAUSE_IR:   next_state = tms ? ST_EXIT2_IR  : ST_PAUSE_IR;
         ST_EXIT2_IR:   next_state = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
         ST_UPDATE_IR:  next_state = tms ? ST_SEL_DR    : ST_IDLE;
         default:       next_state = ST_RESET;
      endcase
   end

   // ----------------------------------------------------------------------
   // controller state register
   // ----------------------------------------------------------------------
   // test reset forces the reset state whatever the test clock does
   always @(posedge CLK_SYS_IN) begin
      if (hold_reset) begin
         state <= ST_RESET;
      end else if (tck_rise) begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------------
   // instruction register
   // ----------------------------------------------------------------------
   // shift stage and active instruction both move on test clock rises
   always @(posedge CLK_SYS_IN) begin
      if (hold_reset) begin
         ir_sh  <= `JDP_IR_RESET;
         IR_OUT <= `JDP_IR_RESET;
      end else if (tck_rise) begin
         case (state)
            ST_RESET:      IR_OUT <= `JDP_IR_RESET;
            ST_CAPTURE_IR: ir_sh  <= `JDP_IR_CAPTURE;
            ST_SHIFT_IR:   ir_sh  <= {tdi, ir_sh[3:1]};
            ST_UPDATE_IR:  IR_OUT <= ir_sh;
            default:       ir_sh  <= ir_sh;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // data register path
   // ----------------------------------------------------------------------
   // one shift stage; its length follows the active instruction
   always @(posedge CLK_SYS_IN) begin
      if (hold_reset) begin
         dr_sh <= 32'h00000000;
      end else if (tck_rise) begin
         if (state == ST_CAPTURE_DR) begin
            case (IR_OUT)
               `JDP_OP_IDCODE: dr_sh <= ID_VALUE;
               `JDP_OP_USER:   dr_sh <= {24'h000000, USER_DATA_IN};
               default:        dr_sh <= 32'h00000000;
            endcase
         end else if (state == ST_SHIFT_DR) begin
            case (IR_OUT)
               `JDP_OP_IDCODE: dr_sh <= {tdi, dr_sh[31:1]};
               `JDP_OP_USER:   dr_sh <= {24'h000000, tdi, dr_sh[7:1]};
               default:        dr_sh <= {31'h00000000, tdi};
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // user register update
   // ----------------------------------------------------------------------
   // update pulse lasts one system clock per update state entry
   always @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         USER_DATA_OUT   <= `JDP_USER_RESET;
         USER_UPDATE_OUT <= 1'b0;
      end else begin
         USER_UPDATE_OUT <= 1'b0;
         if (!hold_reset && tck_rise && state == ST_UPDATE_DR &&
             IR_OUT == `JDP_OP_USER) begin
            USER_DATA_OUT   <= dr_sh[7:0];
            USER_UPDATE_OUT <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // serial output
   // ----------------------------------------------------------------------
   // output and its enable change only on test clock falls
   always @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         TDO_OUT    <= 1'b0;
         TDO_OE_OUT <= 1'b0;
      end else if (tck_fall) begin
         if (factory_sel) begin
            TDO_OUT    <= FACTORY_TDO_IN;
            TDO_OE_OUT <= 1'b1;
         end else begin
            TDO_OUT    <= (state == ST_SHIFT_IR) ? ir_sh[0] : dr_sh[0];
            TDO_OE_OUT <= (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);
         end
      end
   end

   // ----------------------------------------------------------------------
   // return clock, status outputs
   // ----------------------------------------------------------------------
   // return clock echoes the sampled test clock unless single-wire owns it
   always @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         RETURN_TEST_CLOCK_OUT    <= 1'b0;
         RETURN_TEST_CLOCK_OE_OUT <= 1'b0;
         FACTORY_SEL_OUT          <= ~`JDP_SEL_RESET;
         TAP_STATE_OUT            <= ST_RESET;
      end else begin
         RETURN_TEST_CLOCK_OUT    <= tck_level & ~SINGLE_WIRE_EN_IN;
         RETURN_TEST_CLOCK_OE_OUT <= ~SINGLE_WIRE_EN_IN;
         FACTORY_SEL_OUT          <= factory_sel;
         TAP_STATE_OUT            <= state;
      end
   end

endmodule // jdp_port

/* File: verif/jdp_port_props.sv */
// timing checker for the test and debug port pins
`timescale 1ns/1ps
`include "jdp_regs.vh"
module jdp_port_chk (
   input logic       CLK_SYS_IN,
   input logic       RESET_IN,
   input logic       TCK_IN,
   input logic       TRST_N_IN,
   input logic       CTRL_SEL_IN,
   input logic       SINGLE_WIRE_EN_IN,
   input logic       TDO_OUT,
   input logic       TDO_OE_OUT,
   input logic       RETURN_TEST_CLOCK_OUT,
   input logic       RETURN_TEST_CLOCK_OE_OUT,
   input logic       FACTORY_SEL_OUT,
   input logic [3:0] TAP_STATE_OUT,
   input logic [3:0] IR_OUT,
   input logic       USER_UPDATE_OUT
);
   // ---------------------------------------------------------------
   // pin timing properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (RESET_IN);
   sequence s_trst_rel;
      $rose(TRST_N_IN);
   endsequence
   sequence s_tck_fell;
      !$past(TCK_IN, 3) && $past(TCK_IN, 8);
   endsequence
   a_trst_reset: assert property ($fell(TRST_N_IN) |-> ##[1:5] TAP_STATE_OUT == 4'h0)
      else $error("controller not reset by test reset");
   a_trst_hold: assert property (!TRST_N_IN [*6] |-> TAP_STATE_OUT == 4'h0 && IR_OUT == 4'h1)
      else $error("controller left reset while test reset low");
   a_tdo_on_fall: assert property ($changed(TDO_OUT) && !FACTORY_SEL_OUT && TRST_N_IN
      && $past(TRST_N_IN, 8) |-> s_tck_fell) else $error("serial output moved off a falling edge");
   a_oe_on_fall: assert property ($changed(TDO_OE_OUT) && !FACTORY_SEL_OUT && TRST_N_IN
      && $past(TRST_N_IN, 8) |-> s_tck_fell) else $error("output enable moved off a falling edge");
   a_state_on_rise: assert property ($changed(TAP_STATE_OUT) && TAP_STATE_OUT != 4'h0
      |-> $past(TCK_IN, 3) && !$past(TCK_IN, 8)) else $error("state moved without a rising edge");
   a_sel_factory: assert property (s_trst_rel ##0 !CTRL_SEL_IN |-> ##[3:6] FACTORY_SEL_OUT)
      else $error("factory select not latched");
   a_sel_debug: assert property (s_trst_rel ##0 CTRL_SEL_IN |-> ##[3:6] !FACTORY_SEL_OUT)
      else $error("debugger select not latched");
   a_sel_held: assert property ($changed(FACTORY_SEL_OUT) |-> !$past(TRST_N_IN, 5))
      else $error("controller select changed without test reset release");
   a_user_pulse: assert property (USER_UPDATE_OUT |-> $past(TAP_STATE_OUT) == 4'h8
      && IR_OUT == `JDP_OP_USER ##1 !USER_UPDATE_OUT) else $error("bad user update pulse");
   a_return_test_clock_rise: assert property ($rose(RETURN_TEST_CLOCK_OUT) |-> $past(TCK_IN, 3)
      && !$past(TCK_IN, 6) && !SINGLE_WIRE_EN_IN) else $error("return clock rose out of step");
   a_return_test_clock_off: assert property (SINGLE_WIRE_EN_IN [*3] |-> !RETURN_TEST_CLOCK_OUT
      && !RETURN_TEST_CLOCK_OE_OUT) else $error("return clock active with single-wire");
endmodule // jdp_port_chk
bind jdp_port jdp_port_chk chk_u (.CLK_SYS_IN, .RESET_IN, .TCK_IN, .TRST_N_IN, .CTRL_SEL_IN,
   .SINGLE_WIRE_EN_IN, .TDO_OUT, .TDO_OE_OUT, .RETURN_TEST_CLOCK_OUT, .RETURN_TEST_CLOCK_OE_OUT,
   .FACTORY_SEL_OUT, .TAP_STATE_OUT, .IR_OUT, .USER_UPDATE_OUT);

/* File: verif/jdp_dbg_model.sv */
// debugger model driving test clock, mode select, serial input and test reset
`timescale 1ns/1ps
module jdp_dbg_model (
   input  logic clk_in,
   input  logic tdo_in,
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out,
   output logic trst_n_out,
   output logic sel_out
);
   // ---------------------------------------------------------------
   // pin drivers, changed on falling system clock edges
   // ---------------------------------------------------------------
   initial begin
      tck_out = 1'b0;     // clock stands low between frames
      tms_out = 1'b1;
      tdi_out = 1'b0;
      trst_n_out = 1'b1;
      sel_out = 1'b1;     // debugger controller selected
   end
   // one 48 ns test clock period; tms and tdi held across the rise
   task automatic step(input logic t, input logic d, output logic o);
      tms_out = t;
      tdi_out = d;
      repeat (6) @(negedge clk_in);
      o = tdo_in;         // serial output taken just before the rise
      tck_out = 1'b1;
      repeat (6) @(negedge clk_in);
      tck_out = 1'b0;
   endtask
   // test reset level with the select pin set beside it
   task automatic hold_trst(input logic n, input logic s);
      sel_out = s;
      trst_n_out = n;
      repeat (8) @(negedge clk_in);
   endtask
endmodule // jdp_dbg_model

/* File: verif/jdp_port_test.sv */
// self-checking bench for the test and debug port pin logic
`timescale 1ns/1ps
`include "jdp_regs.vh"
module jdp_port_test;
   localparam [31:0] ID_VAL = 32'h4c1d93a7; // arbitrary identity value
   localparam [23:0] TMS_SEQ = 24'hed4f52;
   logic       clk = 1'b0, rst = 1'b1, swe = 1'b0, ftdo = 1'b0;
   logic       tck, tms, tdi, trst_n, sel, tdo, tdo_oe, rtc, rtc_oe, fsel, upd;
   logic [3:0] state, ir;
   logic [7:0] udin = 8'h00, udout;
   int         mismatches = 0, comparisons = 0, pulses = 0, rt_hi = 0, cycles = 0;
   jdp_port #(.ID_VALUE(ID_VAL)) dut_u (.CLK_SYS_IN(clk), .RESET_IN(rst), .TCK_IN(tck),
      .TMS_IN(tms), .TDI_IN(tdi), .TRST_N_IN(trst_n), .CTRL_SEL_IN(sel), .FACTORY_TDO_IN(ftdo),
      .SINGLE_WIRE_EN_IN(swe), .USER_DATA_IN(udin), .TDO_OUT(tdo), .TDO_OE_OUT(tdo_oe),
      .RETURN_TEST_CLOCK_OUT(rtc), .RETURN_TEST_CLOCK_OE_OUT(rtc_oe), .FACTORY_SEL_OUT(fsel),
      .TAP_STATE_OUT(state), .IR_OUT(ir), .USER_DATA_OUT(udout), .USER_UPDATE_OUT(upd));
   jdp_dbg_model m_u (.clk_in(clk), .tdo_in(tdo), .tck_out(tck), .tms_out(tms),
      .tdi_out(tdi), .trst_n_out(trst_n), .sel_out(sel));
   // ---------------------------------------------------------------
   // clock, watch counters and helpers
   // ---------------------------------------------------------------
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (upd === 1'b1) pulses++;
      if (rtc === 1'b1) rt_hi++;
      if (cycles == 20000) begin
         mismatches++;
         results();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", n, e, g);
         mismatches++;
      end
   endtask
   task automatic walk(input logic [7:0] s, input int n);
      logic o;
      for (int i = 0; i < n; i++) m_u.step(s[i], 1'b0, o);
   endtask
   task automatic shift(input int n, input logic [31:0] d, output logic [31:0] q);
      q = 32'h0;
      for (int i = 0; i < n; i++) begin
         m_u.step(i == n - 1, d[i], q[i]);
         chk("tdo_oe", 1, tdo_oe);
      end
      repeat (4) @(negedge clk);
      chk("tdo_oe_off", 0, tdo_oe);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_walk;
      logic [3:0] st [24] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h4, 4'h5, 4'h8, 4'h2,
         4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hb, 4'hc, 4'hf, 4'h1, 4'h2, 4'h9, 4'h0};
      logic o;
      chk("ir", `JDP_IR_RESET, ir);
      chk("fsel", 0, fsel);
      for (int i = 0; i < 24; i++) begin
         m_u.step(TMS_SEQ[i], 1'b0, o);
         chk("state", st[i], state);
      end
   endtask
   task automatic t_shift;
      logic [31:0] q;
      walk(8'h02, 4);
      shift(32, 32'h0, q);
      chk("idcode", ID_VAL, q);
      walk(8'h01, 2);
      walk(8'h03, 4);
      shift(4, 32'h2, q);
      chk("ir_capture", `JDP_IR_CAPTURE, q);
      walk(8'h01, 2);
      chk("ir", `JDP_OP_USER, ir);
      udin = 8'h3c;
      pulses = 0;
      walk(8'h01, 3);
      shift(8, 32'ha5, q);
      chk("user_capture", 8'h3c, q);
      walk(8'h01, 2);
      chk("user_data", 8'ha5, udout);
      chk("user_pulse", 1, pulses);
      walk(8'h03, 4);
      shift(4, 32'hf, q);
      walk(8'h05, 5);
      shift(4, 32'hb, q);
      chk("bypass", 4'h6, q);
      walk(8'h01, 2);
   endtask
   task automatic t_trst;
      logic o;
      m_u.hold_trst(1'b0, 1'b1);
      chk("state", 4'h0, state);
      chk("ir", `JDP_IR_RESET, ir);
      m_u.hold_trst(1'b1, 1'b1);
      m_u.hold_trst(1'b0, 1'b0);
      m_u.hold_trst(1'b1, 1'b0);
      chk("fsel", 1, fsel);
      ftdo = 1'b1;
      walk(8'h00, 1);
      m_u.step(1'b0, 1'b0, o);
      chk("factory_tdo", 1, o);
      chk("state", 4'h0, state);
      ftdo = 1'b0;
      walk(8'h00, 1);
      m_u.hold_trst(1'b0, 1'b1);
      m_u.hold_trst(1'b1, 1'b1);
      chk("fsel", 0, fsel);
   endtask
   task automatic t_return_test_clock;
      swe = 1'b1;
      rt_hi = 0;
      walk(8'h00, 1);
      repeat (6) @(negedge clk);
      chk("return_test_clock_off", 0, rt_hi);
      chk("return_test_clock_oe", 0, rtc_oe);
      swe = 1'b0;
      rt_hi = 0;
      walk(8'h00, 1);
      repeat (6) @(negedge clk);
      chk("return_test_clock_on", 6, rt_hi);
      chk("return_test_clock_oe", 1, rtc_oe);
   endtask
   task automatic results;
      if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_walk();
      t_shift();
      t_trst();
      t_return_test_clock();
      results();
   end
endmodule // jdp_port_test
